// ### serial_target_unit_target.sv
// serial target unit with memory access engine and hardware semaphore
// ----------------------------------------
// Functional notes
// - all four clock modes from polarity and phase bits in configuration
// - done event only after last ram access has finished
// - grab request hands semaphore to cpu and raises granted event
// - give back without cpu ownership is ignored
// - ownership never blocks cpu access to pointers or memory
// - enabling gives semaphore to cpu without granted event
// - grab while cpu owns raises granted event at once
// - select fall tries to take semaphore; failure ignores whole frame
// - ignored frame stays ignored until select rises
// - simultaneous cpu and link attempts favour the cpu
// - granted frame stores mosi bytes and sends transmit buffer
// - granted frame end releases semaphore and raises done event
// - back-to-back frames reuse the same pointers
// - shortcut passes semaphore to cpu after each granted frame
// - cpu request during link ownership granted at frame end
// - with shortcut, one pending request served once after done
// - bytes beyond receive limit set rx excess flag, are dropped
// - bytes beyond transmit limit set tx excess flag, send fill
// - done counts updated at frame end without fill bytes
// - rx buffer full event when receive buffer fills
// - disconnected pin choice detaches that signal
// - miso high impedance while not selected
// ----------------------------------------
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module serial_target_unit_target
    import serial_target_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] mem_addr,
    output logic mem_req,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic csn_pin,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    output logic miso_out,
    output logic miso_oe
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic enable_r;
    logic shortcut_r;
    logic [2:0] config_r;
    logic [31:0] pin_sck_r, pin_miso_r, pin_mosi_r, pin_csn_r;
    logic [31:0] rx_ptr_r, tx_ptr_r;
    logic [15:0] rx_cap_r, tx_cap_r, rx_done_r, tx_done_r;
    logic [7:0] ignored_fill_r, overrun_fill_r;
    logic [1:0] flag_r;
    logic ev_done_r, ev_full_r, ev_grant_r;
    owner_type owner_r;
    logic cpu_pend_r;

    // ----------------------------------------
    // pins and edges
    // ----------------------------------------
    logic csn_lvl, sck_lvl, mosi_lvl, csn_rise, csn_fall, sck_rise, sck_fall;
    logic csn_con, sck_con, mosi_con, miso_con;
    assign csn_con = ~pin_csn_r[pin_connect_bit];
    assign sck_con = ~pin_sck_r[pin_connect_bit];
    assign mosi_con = ~pin_mosi_r[pin_connect_bit];
    assign miso_con = ~pin_miso_r[pin_connect_bit];

    serial_target_unit_pin_sync u_csn (.pclk(pclk), .presetn(presetn), .pin(csn_pin | ~csn_con),
        .level(csn_lvl), .rise(csn_rise), .fall(csn_fall));
    serial_target_unit_pin_sync u_sck (.pclk(pclk), .presetn(presetn), .pin(sck_pin & sck_con),
        .level(sck_lvl), .rise(sck_rise), .fall(sck_fall));
    serial_target_unit_pin_sync u_mosi (.pclk(pclk), .presetn(presetn), .pin(mosi_pin & mosi_con),
        .level(mosi_lvl), .rise(), .fall());

    // leading edge is rise for cpol 0, fall for cpol 1; cpha picks the sampling edge
    logic lead_edge, trail_edge;
    link_ev_type ev;
    assign lead_edge = config_r[cfg_cpol_bit] ? sck_fall : sck_rise;
    assign trail_edge = config_r[cfg_cpol_bit] ? sck_rise : sck_fall;
    assign ev.sel_fall = enable_r & csn_fall;
    assign ev.sel_rise = csn_rise;
    assign ev.sample = ~csn_lvl & (config_r[cfg_cpha_bit] ? trail_edge : lead_edge);
    assign ev.shift = ~csn_lvl & (config_r[cfg_cpha_bit] ? lead_edge : trail_edge);

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic wr_en, rd_en;
    logic grab_task, give_task;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign grab_task = wr_en & (paddr == grab_request_off) & pwdata[0];
    assign give_task = wr_en & (paddr == give_back_off) & pwdata[0];

    logic enable_wr;
    assign enable_wr = wr_en & (paddr == enable_off);

    // ----------------------------------------
    // frame state
    // ----------------------------------------
    typedef enum {st_idle, st_granted, st_ignored, st_drain} frame_type;
    frame_type st_r;
    logic [15:0] rx_cnt_r, tx_cnt_r;
    logic [7:0] tx_byte_r;
    logic wr_pend_r, rd_pend_r;
    logic start_r, first_rd_r, busy_r;
    logic [7:0] wr_byte_r;
    logic [7:0] rx_byte;
    logic rx_valid, tx_need, sh_miso;

    serial_target_unit_shifter u_shift (.pclk(pclk), .presetn(presetn), .start(start_r),
        .sample(ev.sample), .shift(ev.shift), .cpha(config_r[cfg_cpha_bit]),
        .lsb_first(config_r[cfg_lsb_first_bit]), .mosi(mosi_lvl), .tx_byte(tx_byte_r),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_need(tx_need), .miso(sh_miso));

    // link side takes semaphore only if free and the cpu is not asking this cycle
    logic link_take, link_fail, frame_end;
    assign link_take = ev.sel_fall & (owner_r == own_free) & ~grab_task;
    assign link_fail = ev.sel_fall & ~link_take;
    assign frame_end = (st_r == st_drain) & ~wr_pend_r & ~rd_pend_r;

    logic rx_room, tx_room;
    assign rx_room = rx_cnt_r < rx_cap_r;
    assign tx_room = tx_cnt_r < tx_cap_r;

    // acknowledge kind follows the access in flight, not the pending flags
    logic wr_ack, rd_ack, rx_fill;
    assign wr_ack = mem_ack & mem_we;
    assign rd_ack = mem_ack & ~mem_we;
    assign rx_fill = wr_ack & (rx_cnt_r + 16'h0001 == rx_cap_r);

    // ----------------------------------------
    // semaphore
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owner_r <= own_free;
            cpu_pend_r <= 1'b0;
            ev_grant_r <= 1'b0;
        end else begin
            if (enable_wr) begin
                owner_r <= (pwdata[3:0] == enable_value) ? own_cpu : own_free;
                cpu_pend_r <= 1'b0;
            end else if (frame_end) begin
                if (shortcut_r | cpu_pend_r | grab_task) begin
                    owner_r <= own_cpu;
                    ev_grant_r <= 1'b1;
                end else begin
                    owner_r <= own_free;
                end
                cpu_pend_r <= 1'b0;
            end else if (grab_task) begin
                if (owner_r == own_link) begin
                    cpu_pend_r <= 1'b1;
                end else begin
                    owner_r <= own_cpu;
                    ev_grant_r <= 1'b1;
                end
            end else if (give_task && owner_r == own_cpu) begin
                owner_r <= own_free;
            end else if (link_take) begin
                owner_r <= own_link;
            end
            if (wr_en && paddr == granted_event_off) begin
                ev_grant_r <= pwdata[0] | (frame_end & (shortcut_r | cpu_pend_r));
            end
        end
    end

    // ----------------------------------------
    // frame engine and memory access
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= st_idle;
            rx_cnt_r <= 16'h0000;
            tx_cnt_r <= 16'h0000;
            tx_byte_r <= fill_reset;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            wr_byte_r <= 8'h00;
            flag_r <= 2'h0;
            rx_done_r <= 16'h0000;
            tx_done_r <= 16'h0000;
            ev_done_r <= 1'b0;
            ev_full_r <= 1'b0;
            start_r <= 1'b0;
            first_rd_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            case (st_r)
                st_idle: begin
                    if (link_take) begin
                        st_r <= st_granted;
                        rx_cnt_r <= 16'h0000;
                        tx_cnt_r <= 16'h0000;
                        flag_r <= 2'h0;
                        rd_pend_r <= (tx_cap_r != 16'h0000);
                        first_rd_r <= (tx_cap_r != 16'h0000);
                        start_r <= (tx_cap_r == 16'h0000);
                        tx_byte_r <= overrun_fill_r;
                    end else if (link_fail) begin
                        st_r <= st_ignored;
                        tx_byte_r <= ignored_fill_r;
                        start_r <= 1'b1;
                    end
                end
                st_ignored: begin
                    if (ev.sel_rise) begin
                        st_r <= st_idle;
                    end
                end
                st_granted: begin
                    if (rx_valid) begin
                        if (rx_room) begin
                            wr_pend_r <= 1'b1;
                            wr_byte_r <= rx_byte;
                        end else begin
                            flag_r[flag_rx_excess_bit] <= 1'b1;
                        end
                    end
                    if (tx_need) begin
                        if (tx_room) begin
                            rd_pend_r <= 1'b1;
                        end else begin
                            tx_byte_r <= overrun_fill_r;
                            flag_r[flag_tx_excess_bit] <= 1'b1;
                        end
                    end
                    if (ev.sel_rise) begin
                        st_r <= st_drain;
                    end
                end
                st_drain: begin
                    if (frame_end) begin
                        st_r <= st_idle;
                        rx_done_r <= rx_cnt_r;
                        tx_done_r <= tx_cnt_r;
                        ev_done_r <= 1'b1;
                    end
                end
                default: st_r <= st_idle;
            endcase
            // a write serves first; read fetches the next transmit byte
            if (wr_ack) begin
                wr_pend_r <= 1'b0;
                rx_cnt_r <= rx_cnt_r + 16'h0001;
                if (rx_fill) begin
                    ev_full_r <= 1'b1;
                end
            end else if (rd_ack) begin
                rd_pend_r <= 1'b0;
                tx_byte_r <= mem_rdata;
                tx_cnt_r <= tx_cnt_r + 16'h0001;
                first_rd_r <= 1'b0;
                // shifter loads only once the first transmit byte is in
                if (first_rd_r) begin
                    start_r <= 1'b1;
                end
            end
            if (wr_en && paddr == done_event_off) begin
                ev_done_r <= pwdata[0] | frame_end;
            end
            if (wr_en && paddr == rx_full_event_off) begin
                ev_full_r <= pwdata[0] | rx_fill;
            end
        end
    end

    // memory request outputs, registered; one access in flight, request is a one-cycle pulse, address and data held until acknowledged
    logic issue;
    logic [31:0] next_addr;
    assign issue = (wr_pend_r | rd_pend_r) & ~busy_r;
    assign next_addr = wr_pend_r ? rx_ptr_r + {16'h0000, rx_cnt_r} : tx_ptr_r + {16'h0000, tx_cnt_r};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= ptr_reset;
            mem_wdata <= 8'h00;
            busy_r <= 1'b0;
        end else begin
            mem_req <= issue;
            if (issue) begin
                busy_r <= 1'b1;
                mem_we <= wr_pend_r;
                mem_addr <= next_addr;
                mem_wdata <= wr_byte_r;
            end else if (mem_ack) begin
                busy_r <= 1'b0;
            end
        end
    end

    // miso drives only while selected and connected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_out <= sh_miso;
            miso_oe <= ~csn_lvl & miso_con & enable_r;
        end
    end

    // ----------------------------------------
    // register writes (ownership is advisory only)
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= 1'b0;
            shortcut_r <= 1'b0;
            config_r <= 3'h0;
            pin_sck_r <= pin_reset;
            pin_miso_r <= pin_reset;
            pin_mosi_r <= pin_reset;
            pin_csn_r <= pin_reset;
            rx_ptr_r <= ptr_reset;
            tx_ptr_r <= ptr_reset;
            rx_cap_r <= cap_reset;
            tx_cap_r <= cap_reset;
            ignored_fill_r <= fill_reset;
            overrun_fill_r <= fill_reset;
        end else if (wr_en) begin
            case (paddr)
                enable_off: enable_r <= (pwdata[3:0] == enable_value);
                shortcut_off: shortcut_r <= pwdata[2];
                config_off: config_r <= pwdata[2:0];
                pin_sck_off: pin_sck_r <= pwdata;
                pin_miso_off: pin_miso_r <= pwdata;
                pin_mosi_off: pin_mosi_r <= pwdata;
                pin_csn_off: pin_csn_r <= pwdata;
                rx_ptr_off: rx_ptr_r <= pwdata;
                tx_ptr_off: tx_ptr_r <= pwdata;
                rx_cap_off: rx_cap_r <= pwdata[15:0];
                tx_cap_off: tx_cap_r <= pwdata[15:0];
                ignored_fill_off: ignored_fill_r <= pwdata[7:0];
                overrun_fill_off: overrun_fill_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [31:0] rd_mux;
    logic known;
    always_comb begin
        rd_mux = 32'h00000000;
        known = 1'b1;
        case (paddr)
            grab_request_off, give_back_off: rd_mux = 32'h00000000;
            done_event_off: rd_mux = {31'h0, ev_done_r};
            rx_full_event_off: rd_mux = {31'h0, ev_full_r};
            granted_event_off: rd_mux = {31'h0, ev_grant_r};
            shortcut_off: rd_mux = {29'h0, shortcut_r, 2'h0};
            owner_status_off: rd_mux = {30'h0, owner_r};
            flag_status_off: rd_mux = {30'h0, flag_r};
            enable_off: rd_mux = enable_r ? {28'h0, enable_value} : 32'h00000000;
            pin_sck_off: rd_mux = pin_sck_r;
            pin_miso_off: rd_mux = pin_miso_r;
            pin_mosi_off: rd_mux = pin_mosi_r;
            pin_csn_off: rd_mux = pin_csn_r;
            rx_ptr_off: rd_mux = rx_ptr_r;
            rx_cap_off: rd_mux = {16'h0, rx_cap_r};
            rx_done_off: rd_mux = {16'h0, rx_done_r};
            tx_ptr_off: rd_mux = tx_ptr_r;
            tx_cap_off: rd_mux = {16'h0, tx_cap_r};
            tx_done_off: rd_mux = {16'h0, tx_done_r};
            config_off: rd_mux = {29'h0, config_r};
            ignored_fill_off: rd_mux = {24'h0, ignored_fill_r};
            overrun_fill_off: rd_mux = {24'h0, overrun_fill_r};
            default: known = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ### serial_target_unit_pkg.sv
// package: register map, fields, types and constants of the serial target unit
package serial_target_unit_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [11:0] grab_request_off = 12'h024;
    localparam logic [11:0] give_back_off = 12'h028;
    localparam logic [11:0] done_event_off = 12'h104;
    localparam logic [11:0] rx_full_event_off = 12'h110;
    localparam logic [11:0] granted_event_off = 12'h128;
    localparam logic [11:0] shortcut_off = 12'h200;
    localparam logic [11:0] owner_status_off = 12'h400;
    localparam logic [11:0] flag_status_off = 12'h440;
    localparam logic [11:0] enable_off = 12'h500;
    localparam logic [11:0] pin_sck_off = 12'h508;
    localparam logic [11:0] pin_miso_off = 12'h50c;
    localparam logic [11:0] pin_mosi_off = 12'h510;
    localparam logic [11:0] pin_csn_off = 12'h514;
    localparam logic [11:0] rx_ptr_off = 12'h534;
    localparam logic [11:0] rx_cap_off = 12'h538;
    localparam logic [11:0] rx_done_off = 12'h53c;
    localparam logic [11:0] tx_ptr_off = 12'h544;
    localparam logic [11:0] tx_cap_off = 12'h548;
    localparam logic [11:0] tx_done_off = 12'h54c;
    localparam logic [11:0] config_off = 12'h554;
    localparam logic [11:0] ignored_fill_off = 12'h55c;
    localparam logic [11:0] overrun_fill_off = 12'h5c0;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int cfg_lsb_first_bit = 0;
    localparam int cfg_cpha_bit = 1;
    localparam int cfg_cpol_bit = 2;
    localparam int pin_connect_bit = 31;
    localparam int flag_tx_excess_bit = 0;
    localparam int flag_rx_excess_bit = 1;
    localparam logic [3:0] enable_value = 4'h2;
    localparam logic [31:0] pin_reset = 32'hffffffff;
    localparam logic [7:0] fill_reset = 8'h00;
    localparam logic [31:0] ptr_reset = 32'h00000000;
    localparam logic [15:0] cap_reset = 16'h0000;

    // semaphore owner, as read back from the owner status register
    typedef enum logic [1:0] {
        own_free = 2'h0,
        own_cpu = 2'h1,
        own_link = 2'h2
    } owner_type;

    // one memory access request towards the ram
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [7:0] wdata;
    } mem_req_type;

    // edge events from the serial pins
    typedef struct packed {
        logic sel_fall;
        logic sel_rise;
        logic sample;
        logic shift;
    } link_ev_type;

endpackage

// ### serial_target_unit_pin_sync.sv
// two-stage pin synchroniser with edge outputs
`timescale 1ns/10ps
`default_nettype none
module serial_target_unit_pin_sync
    import serial_target_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;
endmodule
`default_nettype wire

// ### serial_target_unit_shifter.sv
// serial byte shifter: samples mosi and presents miso bits
`timescale 1ns/10ps
`default_nettype none
module serial_target_unit_shifter
    import serial_target_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic sample,
    input wire logic shift,
    input wire logic cpha,
    input wire logic lsb_first,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic tx_need,
    output logic miso
);
    logic [7:0] sh_r;
    logic [7:0] out_r;
    logic [2:0] cnt_r;
    logic rx_valid_r;
    logic tx_need_r;
    logic first_r;
    logic [7:0] rx_next;
    logic [7:0] out_shift;

    assign rx_next = lsb_first ? {mosi, sh_r[7:1]} : {sh_r[6:0], mosi};
    assign out_shift = lsb_first ? {1'b0, out_r[7:1]} : {out_r[6:0], 1'b0};
    assign miso = lsb_first ? out_r[0] : out_r[7];
    assign rx_byte = sh_r;
    assign rx_valid = rx_valid_r;
    assign tx_need = tx_need_r;

    // a new byte loads at frame start and after every eighth sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r <= 8'h00;
            out_r <= 8'h00;
            cnt_r <= 3'h0;
            rx_valid_r <= 1'b0;
            tx_need_r <= 1'b0;
            first_r <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            tx_need_r <= 1'b0;
            if (start) begin
                cnt_r <= 3'h0;
                out_r <= tx_byte;
                tx_need_r <= 1'b1;
                first_r <= cpha;
            end else begin
                if (sample) begin
                    sh_r <= rx_next;
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == 3'h7) begin
                        rx_valid_r <= 1'b1;
                    end
                end
                if (shift) begin
                    if (first_r) begin
                        first_r <= 1'b0;
                    end else if (cnt_r == 3'h0) begin
                        out_r <= tx_byte;
                        tx_need_r <= 1'b1;
                    end else begin
                        out_r <= out_shift;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### serial_target_unit_target_chk.sv
// checker: port assertions of the serial target unit
`timescale 1ns/10ps
`default_nettype none
module serial_target_unit_target_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_addr,
    input wire logic csn_pin,
    input wire logic miso_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence idle_s; csn_pin [*5]; endsequence
    ready_next_a: assert property (setup_s |=> pready) else $error("late ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    miso_idle_a: assert property (idle_s |-> !miso_oe) else $error("miso driven");
    oe_start_a: assert property ($rose(miso_oe) |-> !$past(csn_pin, 2)) else $error("early oe");
    mem_pulse_a: assert property (mem_req |=> !mem_req) else $error("long req");
    mem_hold_a: assert property ($past(mem_req) |-> $stable(mem_addr)) else $error("addr moved");
    ack_gap_a: assert property (mem_ack |-> !mem_req) else $error("req overlap");
endmodule
`default_nettype wire

// ### serial_target_unit_master_model.sv
// behavioural serial master driving select, clock and data
`timescale 1ns/10ps
`default_nettype none
module serial_target_unit_master_model (
    input wire logic cpol,
    input wire logic cpha,
    input wire logic miso,
    output logic csn,
    output logic sck,
    output logic mosi
);
    logic [7:0] send_q[$];
    logic [7:0] got_q[$];
    initial begin
        csn = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // one frame of all queued bytes, msb first, clock still outside it
    task automatic frame();
        logic [7:0] b;
        logic [7:0] r;
        sck = cpol;
        #300 csn = 1'b0;
        #500;
        while (send_q.size() > 0) begin
            b = send_q.pop_front();
            for (int i = 7; i >= 0; i--) begin
                if (!cpha) mosi = b[i];
                #62.5 sck = ~sck;
                if (cpha) mosi = b[i]; else r[i] = miso;
                #62.5 sck = ~sck;
                if (cpha) r[i] = miso;
            end
            got_q.push_back(r);
        end
        #500 csn = 1'b1;
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

// ### serial_target_unit_target_tb.sv
// testbench: apb and serial frame checks of the serial target unit
`timescale 1ns/10ps
`default_nettype none
module serial_target_unit_target_tb;
    import serial_target_unit_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mem_ack = 0, cpol = 0, cpha = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, mem_addr;
    logic [7:0] mem_rdata = 0, mem_wdata, ram[256];
    logic pready, pslverr, mem_req, mem_we, miso_out, miso_oe, csn, sck, mosi;
    logic [31:0] exp_q[$];
    int fails = 0, n_compared = 0, seed = 32'hbaaf0bf7;
    serial_target_unit_target uut (.*, .csn_pin(csn), .sck_pin(sck), .mosi_pin(mosi));
    serial_target_unit_master_model m (.cpol(cpol), .cpha(cpha), .miso(miso_oe ? miso_out : 1'bz),
        .csn(csn), .sck(sck), .mosi(mosi));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        mem_ack <= mem_req;
        mem_rdata <= ram[mem_addr[7:0]];
        if (mem_req && mem_we) ram[mem_addr[7:0]] <= mem_wdata;
    end
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk("prdata", exp_q.pop_front(), prdata);
        if (psel && penable && pready) chk("pslverr", 32'(paddr == 12'h004), 32'(pslverr));
    end
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            fails++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic frame(logic ign);
        logic [7:0] s[3];
        for (int i = 0; i < 3; i++) begin
            s[i] = 8'($random(seed));
            m.send_q.push_back(s[i]);
        end
        m.frame();
        repeat (30) @(posedge pclk);
        for (int i = 0; i < 3; i++) chk("miso", ign ? 32'h3c : i < 2 ? 32'(ram[i]) : 32'hc3, 32'(m.got_q.pop_front()));
        for (int i = 0; i < 2; i++) if (!ign) chk("rx ram", 32'(s[i]), 32'(ram[8'h80 + i]));
        $display("frame done ignored=%0d", ign);
    endtask
    initial begin
        for (int i = 0; i < 256; i++) ram[i] = 8'($random(seed));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) apb(1'b1, pin_sck_off + 12'(4 * i), 32'h0);
        apb(1'b1, ignored_fill_off, 32'h3c);
        apb(1'b1, overrun_fill_off, 32'hc3);
        apb(1'b1, rx_ptr_off, 32'h80);
        apb(1'b1, rx_cap_off, 32'h2);
        apb(1'b1, tx_cap_off, 32'h2);
        apb(1'b1, enable_off, 32'(enable_value));
        rd(owner_status_off, 32'(own_cpu));
        rd(granted_event_off, 32'h0);
        apb(1'b1, grab_request_off, 32'h1);
        rd(granted_event_off, 32'h1);
        apb(1'b1, granted_event_off, 32'h0);
        frame(1'b1);
        apb(1'b1, give_back_off, 32'h1);
        apb(1'b1, give_back_off, 32'h1);
        rd(owner_status_off, 32'(own_free));
        for (int md = 0; md < 4; md++) begin
            apb(1'b1, config_off, 32'(md << 1));
            {cpol, cpha} = 2'(md);
            frame(1'b0);
            rd(rx_done_off, 32'h2);
            rd(tx_done_off, 32'h2);
            rd(flag_status_off, 32'h3);
            rd(done_event_off, 32'h1);
            rd(rx_full_event_off, 32'h1);
            rd(owner_status_off, 32'(own_free));
            apb(1'b1, done_event_off, 32'h0);
            apb(1'b1, rx_full_event_off, 32'h0);
        end
        apb(1'b1, shortcut_off, 32'h4);
        frame(1'b0);
        rd(owner_status_off, 32'(own_cpu));
        frame(1'b1);
        rd(12'h004, 32'h0);
        conclude();
    end
endmodule
bind serial_target_unit_target serial_target_unit_target_chk chk (.*);
`default_nettype wire
